// *** rtl/sld_top.sv ***
// Notes on behaviour
// - Stall when measurement below twice threshold
// - Larger measurement means lighter load
// - Stall shown as pulse, not level
// - Pulse only quiet chopper, interval in window
// - Measurement refreshed once per full step
// - Threshold compared, measurement itself never shifted
// - Measurement is ten-bit unsigned
`include "sld_defines.svh"

module sld_top (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic full_step,
  input wire logic [`SLD_LOAD_W-1:0] bemf_load,
  input wire logic quiet_chopper_active,
  input wire logic [`SLD_IVL_W-1:0] step_interval_measure,
  output logic diagnostic_pulse_out,
  output logic irq
);

  sld_pkg::sld_state_s st;
  sld_pkg::sld_state_s next_st;
  sld_pkg::sld_ahb_req_s req;
  logic accept;
  logic gate_ok;
  logic below;
  logic stall_now;
  logic [`SLD_LOAD_W-1:0] doubled;
  logic [31:0] rd_word;
  logic [`SLD_INT_W-1:0] clr;
  logic [`SLD_INT_W-1:0] set_ev;

  assign req = '{sel: hsel, addr: haddr, trans: htrans, write: hwrite,
                 size: hsize, wdata: hwdata, ready: hready};
  assign accept = req.sel && req.trans[1] && req.ready;

  // Threshold doubled and widened to the measurement width
  assign doubled = {1'b0, st.threshold, 1'b0};
  // Raw measurement compared, never offset by the threshold
  assign below = bemf_load < doubled;
  // Stall window: quiet chopper and interval between both limits
  assign gate_ok = quiet_chopper_active
                   && (st.lower_vel >= step_interval_measure)
                   && (step_interval_measure > st.chop_upper);
  // Evaluated only on the update strobe
  assign stall_now = full_step && gate_ok && below;

  // Read data selection
  always_comb begin
    rd_word = 32'h00000000;
    case (st.ap_addr)
      `SLD_OFS_CTRL: begin
        rd_word[`SLD_CTRL_THR_LSB +: `SLD_THR_W] = st.threshold;
        rd_word[`SLD_CTRL_LEN_LSB +: `SLD_LEN_W] = st.pulse_len;
      end
      `SLD_OFS_LOWER_VEL: begin
        rd_word[`SLD_IVL_W-1:0] = st.lower_vel;
      end
      `SLD_OFS_CHOP_UPPER: begin
        rd_word[`SLD_IVL_W-1:0] = st.chop_upper;
      end
      `SLD_OFS_RESULT: begin
        rd_word[`SLD_LOAD_W-1:0] = st.result;
      end
      `SLD_OFS_STEP_IVL: begin
        rd_word[`SLD_IVL_W-1:0] = step_interval_measure;
      end
      `SLD_OFS_INT_STATUS: begin
        rd_word[`SLD_INT_W-1:0] = st.int_status;
      end
      `SLD_OFS_INT_MASK: begin
        rd_word[`SLD_INT_W-1:0] = st.int_mask;
      end
      default: begin
        rd_word = 32'h00000000;
      end
    endcase
  end

  always_comb begin
    next_st = st;
    clr = {`SLD_INT_W{1'b0}};
    next_st.ready = st.ready;
    // Write data phase, zero wait
    if (st.ap_valid && st.ap_write) begin
      next_st.ap_valid = 1'b0;
      case (st.ap_addr)
        `SLD_OFS_CTRL: begin
          next_st.threshold = req.wdata[`SLD_CTRL_THR_LSB +: `SLD_THR_W];
          next_st.pulse_len = req.wdata[`SLD_CTRL_LEN_LSB +: `SLD_LEN_W];
        end
        `SLD_OFS_LOWER_VEL: begin
          next_st.lower_vel = req.wdata[`SLD_IVL_W-1:0];
        end
        `SLD_OFS_CHOP_UPPER: begin
          next_st.chop_upper = req.wdata[`SLD_IVL_W-1:0];
        end
        `SLD_OFS_INT_STATUS: begin
          clr = req.wdata[`SLD_INT_W-1:0];
        end
        `SLD_OFS_INT_MASK: begin
          next_st.int_mask = req.wdata[`SLD_INT_W-1:0];
        end
        default: begin
          next_st.ap_valid = 1'b0;
        end
      endcase
    end
    // Read data phase, one wait state
    if (st.ap_valid && !st.ap_write) begin
      next_st.ap_valid = 1'b0;
      next_st.rdata = rd_word;
      next_st.ready = 1'b1;
    end
    if (accept) begin
      next_st.ap_valid = 1'b1;
      next_st.ap_write = req.write;
      next_st.ap_addr = req.addr[7:0];
      if (!req.write) begin
        next_st.ready = 1'b0;
      end
    end
    // Measurement latched only on a full step, unmodified
    if (full_step) begin
      next_st.result = bemf_load;
    end
    next_st.step_seen = full_step;
    next_st.stall_trig = stall_now;
    // Sticky events, a new event beats a clear
    set_ev = {`SLD_INT_W{1'b0}};
    set_ev[`SLD_INT_STALL] = st.stall_trig;
    set_ev[`SLD_INT_UPDATE] = st.step_seen;
    next_st.int_status = (st.int_status & ~clr) | set_ev;
    next_st.irq = |(next_st.int_status & next_st.int_mask);
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
      st.ready <= 1'b1;
      st.threshold <= `SLD_RST_THR;
      st.pulse_len <= `SLD_RST_LEN;
      st.lower_vel <= `SLD_RST_LOWER_VEL;
      st.chop_upper <= `SLD_RST_CHOP_UPPER;
      st.int_mask <= `SLD_RST_INT_MASK;
    end else begin
      st <= next_st;
    end
  end

  // Stall shown as a bounded pulse on the diagnostic pin
  sld_pulse_stretch u_stretch (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .trig(st.stall_trig),
    .len(st.pulse_len),
    .pulse(diagnostic_pulse_out)
  );

  assign hrdata = st.rdata;
  assign hreadyout = st.ready;
  assign hresp = 1'b0;
  assign irq = st.irq;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  stall_compare_a: assert property (
    full_step && gate_ok && ({1'b0, bemf_load} < {2'b00, st.threshold, 1'b0})
    |=> st.stall_trig ##1 diagnostic_pulse_out)
    else $error("stall below doubled threshold not flagged");

  no_false_stall_a: assert property (
    full_step && (bemf_load >= {1'b0, st.threshold, 1'b0})
    |=> !st.stall_trig)
    else $error("stall flagged at or above doubled threshold");

  result_hold_a: assert property (
    !full_step |=> $stable(st.result))
    else $error("measurement changed without a full step");

  result_load_a: assert property (
    full_step |=> st.result == $past(bemf_load))
    else $error("measurement not latched on full step");

  result_sense_a: assert property (
    full_step && bemf_load > st.result |=> st.result > $past(st.result))
    else $error("measurement sense inverted");

  stall_gate_a: assert property (
    st.stall_trig |-> $past(quiet_chopper_active)
      && $past(st.lower_vel >= step_interval_measure)
      && $past(step_interval_measure > st.chop_upper))
    else $error("stall pulse outside enable window");

  one_per_step_a: assert property (
    st.stall_trig |-> $past(full_step))
    else $error("stall event without measurement update");

  pulse_single_a: assert property (
    st.stall_trig && st.pulse_len == 8'h01 && !stall_now
    |=> diagnostic_pulse_out ##1 !diagnostic_pulse_out)
    else $error("diagnostic output held instead of pulsed");

  read_wait_a: assert property (
    st.ap_valid && !st.ap_write |-> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");

  stall_sticky_a: assert property (
    st.stall_trig |=> st.int_status[`SLD_INT_STALL])
    else $error("stall status bit not set");

  pulse_from_trig_a: assert property (
    st.stall_trig |=> diagnostic_pulse_out)
    else $error("stall trigger gave no diagnostic pulse");

  pulse_cause_a: assert property (
    $rose(diagnostic_pulse_out) |-> $past(st.stall_trig))
    else $error("diagnostic pulse without stall trigger");

  idle_no_stall_a: assert property (
    !full_step |=> !st.stall_trig)
    else $error("stall evaluated between full steps");

  window_gate_a: assert property (
    full_step && !gate_ok |=> !st.stall_trig)
    else $error("stall flagged outside enable window");

  quiet_gate_a: assert property (
    full_step && !quiet_chopper_active |=> !st.stall_trig)
    else $error("stall flagged with quiet chopper off");

  upper_gate_a: assert property (
    full_step && (step_interval_measure <= st.chop_upper)
    |=> !st.stall_trig)
    else $error("stall flagged at or below upper switch limit");

  lower_gate_a: assert property (
    full_step && (step_interval_measure > st.lower_vel)
    |=> !st.stall_trig)
    else $error("stall flagged above lower velocity limit");

  result_read_a: assert property (
    st.ap_valid && !st.ap_write && (st.ap_addr == `SLD_OFS_RESULT)
    |=> hrdata == {22'h000000, $past(st.result)})
    else $error("measurement readback not ten bits");

  update_flag_a: assert property (
    st.step_seen |=> st.int_status[`SLD_INT_UPDATE])
    else $error("update status bit not set");

  irq_match_a: assert property (
    irq == (|(st.int_status & st.int_mask)))
    else $error("interrupt output disagrees with status");

  write_no_wait_a: assert property (
    st.ap_valid && st.ap_write |-> hreadyout)
    else $error("write data phase stalled");

  ready_idle_a: assert property (
    !st.ap_valid |-> hreadyout)
    else $error("bus not ready while idle");

  rdata_hold_a: assert property (
    !(st.ap_valid && !st.ap_write) |=> $stable(hrdata))
    else $error("read data changed outside a read");

  status_clear_a: assert property (
    st.ap_valid && st.ap_write && (st.ap_addr == `SLD_OFS_INT_STATUS)
    && hwdata[`SLD_INT_STALL] && !st.stall_trig
    |=> !st.int_status[`SLD_INT_STALL])
    else $error("stall status bit not cleared");

  ctrl_write_a: assert property (
    st.ap_valid && st.ap_write && (st.ap_addr == `SLD_OFS_CTRL)
    |=> st.threshold == $past(hwdata[`SLD_CTRL_THR_LSB +: `SLD_THR_W])
    && st.pulse_len == $past(hwdata[`SLD_CTRL_LEN_LSB +: `SLD_LEN_W]))
    else $error("control write not applied");

  mask_write_a: assert property (
    st.ap_valid && st.ap_write && (st.ap_addr == `SLD_OFS_INT_MASK)
    |=> st.int_mask == $past(hwdata[`SLD_INT_W-1:0]))
    else $error("mask write not applied");

  pulse_three_a: assert property (
    st.stall_trig && st.pulse_len == 8'h03 && !stall_now
    ##1 !stall_now ##1 !stall_now
    |=> diagnostic_pulse_out ##1 !diagnostic_pulse_out)
    else $error("three cycle pulse has wrong length");

  pulse_zero_a: assert property (
    st.stall_trig && st.pulse_len == 8'h00 && !stall_now
    |=> diagnostic_pulse_out ##1 !diagnostic_pulse_out)
    else $error("zero length pulse not one cycle");

endmodule

// *** rtl/sld_defines.svh ***
`ifndef SLD_DEFINES_SVH
`define SLD_DEFINES_SVH

// Field widths
`define SLD_LOAD_W 10
`define SLD_THR_W 8
`define SLD_LEN_W 8
`define SLD_IVL_W 20
`define SLD_INT_W 2

// Register byte offsets
`define SLD_OFS_CTRL 8'h00
`define SLD_OFS_LOWER_VEL 8'h04
`define SLD_OFS_CHOP_UPPER 8'h08
`define SLD_OFS_RESULT 8'h0C
`define SLD_OFS_STEP_IVL 8'h10
`define SLD_OFS_INT_STATUS 8'h14
`define SLD_OFS_INT_MASK 8'h18

// Control register field positions
`define SLD_CTRL_THR_LSB 0
`define SLD_CTRL_LEN_LSB 8

// Interrupt bit positions
`define SLD_INT_STALL 0
`define SLD_INT_UPDATE 1

// Reset values
`define SLD_RST_THR 8'h00
`define SLD_RST_LEN 8'h01
`define SLD_RST_LOWER_VEL 20'h00000
`define SLD_RST_CHOP_UPPER 20'h00000
`define SLD_RST_INT_MASK 2'h0

`endif

// *** rtl/sld_pkg.sv ***
`include "sld_defines.svh"

package sld_pkg;

  typedef struct packed {
    logic [`SLD_LEN_W-1:0] cnt;
    logic pulse;
  } sld_stretch_s;

  typedef struct packed {
    logic ready;
    logic ap_valid;
    logic ap_write;
    logic [7:0] ap_addr;
    logic [31:0] rdata;
    logic [`SLD_THR_W-1:0] threshold;
    logic [`SLD_LEN_W-1:0] pulse_len;
    logic [`SLD_IVL_W-1:0] lower_vel;
    logic [`SLD_IVL_W-1:0] chop_upper;
    logic [`SLD_LOAD_W-1:0] result;
    logic [`SLD_INT_W-1:0] int_status;
    logic [`SLD_INT_W-1:0] int_mask;
    logic irq;
    logic stall_trig;
    logic step_seen;
  } sld_state_s;

  typedef struct packed {
    logic sel;
    logic [31:0] addr;
    logic [1:0] trans;
    logic write;
    logic [2:0] size;
    logic [31:0] wdata;
    logic ready;
  } sld_ahb_req_s;

endpackage

// *** rtl/sld_pulse_stretch.sv ***
`include "sld_defines.svh"

module sld_pulse_stretch (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic trig,
  input wire logic [`SLD_LEN_W-1:0] len,
  output logic pulse
);

  sld_pkg::sld_stretch_s st;
  sld_pkg::sld_stretch_s next_st;

  // A length of zero behaves as one cycle
  always_comb begin
    next_st = st;
    if (trig) begin
      next_st.pulse = 1'b1;
      if (len == {`SLD_LEN_W{1'b0}}) begin
        next_st.cnt = {`SLD_LEN_W{1'b0}};
      end else begin
        next_st.cnt = len - 8'h01;
      end
    end else if (st.cnt != {`SLD_LEN_W{1'b0}}) begin
      next_st.pulse = 1'b1;
      next_st.cnt = st.cnt - 8'h01;
    end else begin
      next_st.pulse = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pulse = st.pulse;

endmodule

// *** sim/sld_motion_ctrl.sv ***
module sld_motion_ctrl (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic diagnostic_pulse_out,
  output logic halted,
  output logic [7:0] stall_count
);
  timeunit 1ns;
  timeprecision 1ns;
  logic prev;
  // Each new pulse is one stall; halted asks to stop stepping
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      prev <= 1'b0;
      halted <= 1'b0;
      stall_count <= 8'h00;
    end else begin
      prev <= diagnostic_pulse_out;
      if (diagnostic_pulse_out && !prev) begin
        stall_count <= stall_count + 8'h01;
        halted <= 1'b1;
      end
    end
  end
endmodule

// *** sim/sld_top_test.sv ***
`include "sld_defines.svh"

module sld_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, nrst, hsel, hwrite, full_step, quiet_chopper_active;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp, diagnostic_pulse_out, irq, halted, rd_phase;
  logic [`SLD_LOAD_W-1:0] bemf_load;
  logic [`SLD_IVL_W-1:0] step_interval_measure;
  logic [7:0] stall_count;
  logic [31:0] q[$];
  int bad_count, n_checks, n_stall;

  sld_top DUT (.sys_clk(sys_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .full_step(full_step), .bemf_load(bemf_load),
    .quiet_chopper_active(quiet_chopper_active),
    .step_interval_measure(step_interval_measure),
    .diagnostic_pulse_out(diagnostic_pulse_out), .irq(irq));
  sld_motion_ctrl ctrl (.sys_clk(sys_clk), .nrst(nrst),
    .diagnostic_pulse_out(diagnostic_pulse_out), .halted(halted),
    .stall_count(stall_count));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Read data is compared against the oldest expectation
  always @(posedge sys_clk) begin
    if (rd_phase && hreadyout) chk(hrdata, q.pop_front());
  end

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h000000, a};
    hsize <= 3'h2;
    @(posedge sys_clk);
    while (!hreadyout) @(posedge sys_clk);
    htrans <= 2'h0;
    hwdata <= d;
    rd_phase <= !w;
    @(posedge sys_clk);
    while (!hreadyout) @(posedge sys_clk);
    chk({31'h0, hresp}, 32'h0);
    rd_phase <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    q.push_back(e);
    bus(1'b0, a, 32'h00000000);
  endtask

  task automatic step(input logic [9:0] ld, input logic [19:0] ivl,
                      input logic qa, input int len, input logic e);
    full_step <= 1'b1;
    bemf_load <= ld;
    step_interval_measure <= ivl;
    quiet_chopper_active <= qa;
    @(posedge sys_clk);
    full_step <= 1'b0;
    @(posedge sys_clk);
    for (int i = 0; i < len; i++) begin
      #1 chk({31'h0, diagnostic_pulse_out}, {31'h0, e});
      @(posedge sys_clk);
    end
    #1 chk({31'h0, diagnostic_pulse_out}, 32'h0);
    n_stall += e;
    rd(`SLD_OFS_RESULT, {22'h0, ld});
  endtask

  task automatic irq_is(input logic e);
    @(posedge sys_clk);
    #1 chk({31'h0, irq}, {31'h0, e});
  endtask

  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    stop_test();
  end

  initial begin
    {nrst, hsel, hwrite, full_step, quiet_chopper_active, rd_phase} = '0;
    {haddr, hwdata, htrans, hsize, bemf_load, step_interval_measure} = '0;
    void'($urandom(32'h261d));
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    rd(`SLD_OFS_CTRL, 32'h00000100);
    for (int a = 4; a < 32; a += 4) rd(a[7:0], 32'h0);
    $display("reset values done");
    bus(1'b1, `SLD_OFS_CTRL, 32'h00000104);
    bus(1'b1, `SLD_OFS_LOWER_VEL, 32'h000003E8);
    bus(1'b1, `SLD_OFS_CHOP_UPPER, 32'h00000064);
    rd(`SLD_OFS_LOWER_VEL, 32'h000003E8);
    step(10'($urandom % 8), 20'h3E8, 1'b1, 1, 1'b1);
    step(10'h008, 20'h1F4, 1'b1, 1, 1'b0);
    step(10'h000, 20'h065, 1'b1, 1, 1'b1);
    step(10'h003, 20'h064, 1'b1, 1, 1'b0);
    step(10'h003, 20'h3E9, 1'b1, 1, 1'b0);
    step(10'h003, 20'h1F4, 1'b0, 1, 1'b0);
    step(10'($urandom % 1016 + 8), 20'h1F4, 1'b1, 1, 1'b0);
    step(10'h3FF, 20'h1F4, 1'b1, 1, 1'b0);
    $display("stall window done");
    rd(`SLD_OFS_INT_STATUS, 32'h3);
    irq_is(1'b0);
    bus(1'b1, `SLD_OFS_INT_MASK, 32'h1);
    irq_is(1'b1);
    bus(1'b1, `SLD_OFS_INT_STATUS, 32'h1);
    irq_is(1'b0);
    rd(`SLD_OFS_INT_STATUS, 32'h2);
    bus(1'b1, `SLD_OFS_INT_MASK, 32'h0);
    step(10'h001, 20'h1F4, 1'b1, 1, 1'b1);
    irq_is(1'b0);
    $display("interrupt done");
    bus(1'b1, `SLD_OFS_CTRL, 32'h00000304);
    step(10'h002, 20'h1F4, 1'b1, 3, 1'b1);
    bus(1'b1, `SLD_OFS_CTRL, 32'h00000004);
    step(10'h002, 20'h1F4, 1'b1, 1, 1'b1);
    bus(1'b1, `SLD_OFS_RESULT, 32'h000003FF);
    bus(1'b1, 8'h1C, 32'hFFFFFFFF);
    rd(`SLD_OFS_RESULT, 32'h2);
    rd(8'h1C, 32'h0);
    rd(`SLD_OFS_CTRL, 32'h00000004);
    rd(`SLD_OFS_CHOP_UPPER, 32'h00000064);
    rd(`SLD_OFS_STEP_IVL, 32'h000001F4);
    $display("pulse length done");
    repeat (3) @(posedge sys_clk);
    chk({24'h0, stall_count}, n_stall);
    chk({31'h0, halted}, 32'h1);
    chk(q.size(), 32'h0);
    stop_test();
  end
endmodule
